// ---- core/pmc_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the power-mode clock controller.
// Included by the package and by the controller; definitions only.
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define PMC_CTRL_OFS 8'h00
`define PMC_STAT_OFS 8'h04

// ----------------------------------------------------------------
// Oscillator control register fields
// ----------------------------------------------------------------
`define PMC_SRC_LO 0
`define PMC_SRC_HI 1
`define PMC_SEC_EN_BIT 3
`define PMC_DUAL_BIT 4
`define PMC_MON_BIT 5
`define PMC_GATE_BIT 7
`define PMC_CTRL_RST 8'h00
`define PMC_CTRL_MASK 8'hBB

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define PMC_PRI_FLAG_BIT 0
`define PMC_SEC_FLAG_BIT 1
`define PMC_INT_FLAG_BIT 2
`define PMC_SRC_POS 4
`define PMC_CPU_EN_BIT 8
`define PMC_PER_EN_BIT 9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PMC_CLK_MHZ 200
`define PMC_WAKE_US 10
`define PMC_WAKE_CYCLES (`PMC_WAKE_US * `PMC_CLK_MHZ)
`define PMC_SWITCH_CYCLES 8

`endif

// ---- core/pmc_pkg.sv ----
// Types shared by the power-mode clock controller.
// Assumes pmc_cfg.svh is on the include path.
package pmc_pkg;
  `include "pmc_cfg.svh"

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_PRI = 2'h1,
    SRC_SEC = 2'h2,
    SRC_INT = 2'h3
  } pmc_src_t;

  typedef enum logic [2:0] {
    ST_RUN_PRI,
    ST_RUN_ALT,
    ST_SWITCH,
    ST_IDLE,
    ST_SLEEP,
    ST_WAKE_DLY,
    ST_WAIT_PRI
  } pmc_state_t;

  // Clock-active status flags
  typedef struct packed {
    logic int_osc_stable_flag;
    logic secondary_clock_active_flag;
    logic primary_clock_active_flag;
  } pmc_flags_t;

  // Clock gating and source outputs
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic pri_osc_en;
    pmc_src_t clk_sel;
  } pmc_clk_t;
endpackage

// ---- core/pmc_ctrl.sv ----
// Power-mode clock controller: sleep decode, clock source switching, wake sequencing.
// Assumes a single 200 MHz clock, an AXI4-Lite master on the same clock and
// oscillator status inputs that arrive asynchronously.
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_ctrl
  import pmc_pkg::*;
#(
  parameter int ADDR_W = 8  // AXI address width
) (
  input wire logic sys_clk,  // System clock, 200 MHz
  input wire logic rst,  // Asynchronous reset, active high
  input wire logic sleep_req,  // Sleep instruction executed, one-cycle pulse
  input wire logic wake_irq,  // Interrupt wake request
  input wire logic wake_wdt,  // Watchdog time-out, one-cycle pulse
  input wire logic pri_ready,  // Primary clock ready, asynchronous
  input wire logic sec_osc_running,  // Secondary oscillator running, asynchronous
  input wire logic int_osc_stable,  // Internal oscillator stable, asynchronous
  output pmc_clk_t clk_ctl,  // Gating and source selection
  output pmc_flags_t flags,  // Clock-active flags
  output logic wdt_reset,  // Watchdog reset request, one-cycle pulse
  input wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
  input wire logic s_axi_awvalid,  // Write address valid
  output logic s_axi_awready,  // Write address ready
  input wire logic [31:0] s_axi_wdata,  // Write data
  input wire logic [3:0] s_axi_wstrb,  // Write strobes
  input wire logic s_axi_wvalid,  // Write data valid
  output logic s_axi_wready,  // Write data ready
  output logic [1:0] s_axi_bresp,  // Write response
  output logic s_axi_bvalid,  // Write response valid
  input wire logic s_axi_bready,  // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
  input wire logic s_axi_arvalid,  // Read address valid
  output logic s_axi_arready,  // Read address ready
  output logic [31:0] s_axi_rdata,  // Read data
  output logic [1:0] s_axi_rresp,  // Read response
  output logic s_axi_rvalid,  // Read valid
  input wire logic s_axi_rready  // Read ready
);

  localparam int WAKE_CYCLES = `PMC_WAKE_CYCLES;
  localparam int SWITCH_CYCLES = `PMC_SWITCH_CYCLES;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // ----------------------------------------------------------------
  // Oscillator status synchronisers
  // ----------------------------------------------------------------
  // A change is accepted only once stages two and three agree, which
  // rejects a single-cycle glitch leaving the first stage.
  logic [2:0] async_in;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] filt_q;
  logic [2:0] sync_clr;
  assign async_in = {int_osc_stable, sec_osc_running, pri_ready};
  assign sync_clr = {2'b00, !clk_ctl.pri_osc_en};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          filt_q[gi] <= 1'b0;
        end else if (sync_clr[gi]) begin
          // A stopped primary must not leave a stale ready in the chain
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          filt_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            filt_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  logic pri_rdy_f;
  logic secondary_run_mode_f;
  logic int_stb_f;
  assign pri_rdy_f = filt_q[0];
  assign secondary_run_mode_f = filt_q[1];
  assign int_stb_f = filt_q[2];

  // ----------------------------------------------------------------
  // AXI4-Lite register slave
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic aw_q;
  logic w_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wstrb0_q;
  logic wr_go;
  logic wr_ctrl;
  logic [31:0] stat_word;

  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_q && w_q;
  assign wr_ctrl = wr_go && (awaddr_q == ADDR_W'(`PMC_CTRL_OFS)) && wstrb0_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == ADDR_W'(`PMC_CTRL_OFS) || awaddr_q == ADDR_W'(`PMC_STAT_OFS)) begin
          s_axi_bresp <= RESP_OK;
        end else begin
          s_axi_bresp <= RESP_ERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only software writes the control bits; no wake path touches them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `PMC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wbyte_q & `PMC_CTRL_MASK;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OK;
      if (s_axi_araddr == ADDR_W'(`PMC_CTRL_OFS)) begin
        s_axi_rdata <= {24'h00_0000, ctrl_q};
      end else if (s_axi_araddr == ADDR_W'(`PMC_STAT_OFS)) begin
        s_axi_rdata <= stat_word;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_ERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sleep decode
  // ----------------------------------------------------------------
  logic cpu_gate_bit;
  logic [1:0] clock_source_select;
  logic secondary_osc_enable;
  logic alt_start;
  pmc_src_t sel_src;
  assign cpu_gate_bit = ctrl_q[`PMC_GATE_BIT];
  assign clock_source_select = ctrl_q[`PMC_SRC_HI:`PMC_SRC_LO];
  assign secondary_osc_enable = ctrl_q[`PMC_SEC_EN_BIT];
  assign alt_start = ctrl_q[`PMC_DUAL_BIT] || ctrl_q[`PMC_MON_BIT];

  // Upper select bit alone picks the internal block
  always_comb begin
    if (clock_source_select[1]) begin
      sel_src = SRC_INT;
    end else if (clock_source_select[0]) begin
      sel_src = SRC_SEC;
    end else begin
      sel_src = SRC_PRI;
    end
  end

  // ----------------------------------------------------------------
  // Power-mode sequencer
  // ----------------------------------------------------------------
  pmc_state_t state_q;
  pmc_state_t ret_q;
  pmc_src_t src_q;
  pmc_src_t tgt_q;
  logic [11:0] cnt_q;
  logic cpu_running;
  logic wake_any;
  logic sleep_000;
  logic sleep_bad;

  assign cpu_running = (state_q == ST_RUN_PRI) || (state_q == ST_RUN_ALT) ||
                       (state_q == ST_WAIT_PRI && src_q != SRC_NONE);
  assign wake_any = wake_irq || wake_wdt;
  assign sleep_000 = !cpu_gate_bit && clock_source_select == 2'h0;
  assign sleep_bad = sel_src == SRC_SEC && !secondary_osc_enable;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RUN_PRI;
      ret_q <= ST_RUN_PRI;
      src_q <= SRC_PRI;
      tgt_q <= SRC_PRI;
      cnt_q <= 12'h000;
      wdt_reset <= 1'b0;
    end else begin
      wdt_reset <= 1'b0;
      unique case (state_q)
        ST_RUN_PRI, ST_RUN_ALT, ST_WAIT_PRI: begin
          if (wake_wdt && state_q != ST_RUN_PRI) begin
            wdt_reset <= 1'b1;
          end else if (sleep_req && sleep_000) begin
            state_q <= ST_SLEEP;
            src_q <= SRC_NONE;
          end else if (sleep_req && !sleep_bad) begin
            // Bits as they stand now pick the mode
            ret_q <= cpu_gate_bit ? ST_IDLE : ST_RUN_ALT;
            if (sel_src != src_q) begin
              state_q <= ST_SWITCH;
              tgt_q <= sel_src;
              cnt_q <= 12'h000;
            end else begin
              state_q <= cpu_gate_bit ? ST_IDLE : ST_RUN_ALT;
            end
          end else if (state_q == ST_RUN_ALT && src_q == SRC_SEC && !secondary_osc_enable) begin
            state_q <= ST_WAIT_PRI;
          end else if (state_q == ST_RUN_ALT && wake_irq) begin
            state_q <= ST_WAIT_PRI;
          end else if (state_q == ST_WAIT_PRI && pri_rdy_f) begin
            state_q <= ST_SWITCH;
            tgt_q <= SRC_PRI;
            ret_q <= ST_RUN_PRI;
            cnt_q <= 12'h000;
          end
        end
        ST_SWITCH: begin
          // Settle on the new source; the secondary must oscillate first
          if (tgt_q != SRC_SEC || secondary_run_mode_f) begin
            if (cnt_q == 12'(SWITCH_CYCLES - 1)) begin
              src_q <= tgt_q;
              state_q <= (ret_q == ST_RUN_ALT && tgt_q == SRC_PRI) ? ST_RUN_PRI : ret_q;
            end else begin
              cnt_q <= cnt_q + 12'h001;
            end
          end
        end
        ST_IDLE: begin
          if (wake_any) begin
            state_q <= ST_WAKE_DLY;
            cnt_q <= 12'h000;
          end
        end
        ST_SLEEP: begin
          if (wake_any) begin
            state_q <= ST_WAIT_PRI;
            src_q <= alt_start ? SRC_INT : SRC_NONE;
          end
        end
        ST_WAKE_DLY: begin
          if (cnt_q == 12'(WAKE_CYCLES - 1)) begin
            state_q <= (src_q == SRC_PRI) ? ST_RUN_PRI : ST_WAIT_PRI;
          end else begin
            cnt_q <= cnt_q + 12'h001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock gating and flags
  // ----------------------------------------------------------------
  // Flags follow src_q, which moves at the end of a switch, on entry to full sleep and on wake from it, so the
  // hand-over between flags is glitch free and one-hot at most.
  assign flags.primary_clock_active_flag = src_q == SRC_PRI;
  assign flags.secondary_clock_active_flag = src_q == SRC_SEC;
  assign flags.int_osc_stable_flag = src_q == SRC_INT && int_stb_f;

  assign clk_ctl.cpu_clk_en = cpu_running;
  assign clk_ctl.periph_clk_en = cpu_running || state_q == ST_IDLE ||
                                 state_q == ST_WAKE_DLY;
  assign clk_ctl.pri_osc_en = (src_q == SRC_PRI) || state_q == ST_WAIT_PRI ||
                              (state_q == ST_SWITCH && tgt_q == SRC_PRI);
  assign clk_ctl.clk_sel = src_q;

  assign stat_word = {22'h00_0000, clk_ctl.periph_clk_en, clk_ctl.cpu_clk_en,
                      2'h0, src_q, 1'b0, flags};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_full_sleep: assert property (
    @(posedge sys_clk) disable iff (rst)
    sleep_req && state_q == ST_RUN_PRI && sleep_000 |=>
      state_q == ST_SLEEP && !flags.primary_clock_active_flag && !clk_ctl.pri_osc_en)
    else $error("sleep with all-zero bits did not enter full sleep");

  a_wdt_reset: assert property (
    @(posedge sys_clk) disable iff (rst)
    wake_wdt && (state_q == ST_RUN_ALT || state_q == ST_WAIT_PRI) |=> wdt_reset)
    else $error("watchdog in run mode gave no reset");

  a_idle_exit: assert property (
    @(posedge sys_clk) disable iff (rst)
    state_q == ST_IDLE && !wake_irq && !wake_wdt |=> state_q == ST_IDLE)
    else $error("idle left without a wake event");

  a_ctrl_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    !wr_ctrl |=> $stable(ctrl_q))
    else $error("control bits changed without a software write");

  a_sec_ignore: assert property (
    @(posedge sys_clk) disable iff (rst)
    sleep_req && state_q == ST_RUN_PRI && !wake_wdt && sleep_bad && !sleep_000 |=>
      state_q == ST_RUN_PRI)
    else $error("secondary mode entered with oscillator disabled");

  a_wake_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    state_q == ST_IDLE && wake_any |=> !clk_ctl.cpu_clk_en [*8])
    else $error("CPU clocked too soon after idle wake");

  a_wake_count: assert property (
    @(posedge sys_clk) disable iff (rst)
    state_q == ST_WAKE_DLY && cnt_q != 12'(WAKE_CYCLES - 1) |=> state_q == ST_WAKE_DLY)
    else $error("wake delay ended early");

  a_primary_idle_mode: assert property (
    @(posedge sys_clk) disable iff (rst)
    state_q == ST_IDLE && src_q == SRC_PRI |->
      flags.primary_clock_active_flag && clk_ctl.pri_osc_en && !clk_ctl.cpu_clk_en)
    else $error("primary idle lost oscillator or flag");

  a_switchback: assert property (
    @(posedge sys_clk) disable iff (rst)
    state_q == ST_WAIT_PRI && pri_rdy_f && !sleep_req && !wake_wdt |=>
      state_q == ST_SWITCH && tgt_q == SRC_PRI ##8 state_q == ST_RUN_PRI)
    else $error("switchback to primary did not complete in time");

  a_sec_wait: assert property (
    @(posedge sys_clk) disable iff (rst)
    state_q == ST_SWITCH && tgt_q == SRC_SEC && !secondary_run_mode_f |=>
      state_q == ST_SWITCH && !clk_ctl.periph_clk_en)
    else $error("peripherals clocked before secondary started");

endmodule

// ---- testbench/pmc_osc_model.sv ----
// Far-side model: the oscillators whose status the controller watches.
// Assumes the bench sets the primary start-up time and starts the secondary.
`timescale 1ns/1ps
module pmc_osc_model
  import pmc_pkg::*;
(
  input wire logic sys_clk,  // System clock
  input wire logic rst,  // Asynchronous reset, active high
  input wire pmc_clk_t clk_ctl,  // Gating and source outputs of the controller
  input wire logic sec_on,  // Secondary oscillator started by software
  input wire logic [15:0] pri_dly,  // Primary start-up time in cycles
  output logic pri_ready,  // Primary clock ready
  output logic sec_osc_running,  // Secondary oscillator running
  output logic int_osc_stable  // Internal oscillator stable
);
  logic [15:0] age_q;

  // A stopped primary restarts from zero, so it is never ready at once
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      age_q <= 16'hFFFF;
    end else if (!clk_ctl.pri_osc_en) begin
      age_q <= 16'h0000;
    end else if (age_q != 16'hFFFF) begin
      age_q <= age_q + 16'h0001;
    end
  end

  assign pri_ready = clk_ctl.pri_osc_en && (age_q >= pri_dly);
  assign sec_osc_running = sec_on;
  assign int_osc_stable = !rst;
endmodule

// ---- testbench/test_power_mode_clock_gating_controller.sv ----
// Self-checking bench for the power-mode clock controller.
// Assumes pmc_pkg and pmc_osc_model are compiled first.
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module test_power_mode_clock_gating_controller
  import pmc_pkg::*;
;
  logic sys_clk, rst, sleep_req, wake_irq, wake_wdt, sec_on, wdt_reset;
  logic pri_ready, sec_osc_running, int_osc_stable;
  logic [15:0] pri_dly;
  pmc_clk_t clk_ctl;
  pmc_flags_t flags;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rng;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int mismatches, checked, wdt_pulses;

  pmc_ctrl #(.ADDR_W(8)) dut_u (.sys_clk, .rst, .sleep_req, .wake_irq, .wake_wdt,
    .pri_ready, .sec_osc_running, .int_osc_stable, .clk_ctl, .flags, .wdt_reset,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  pmc_osc_model osc_u (.sys_clk, .rst, .clk_ctl, .sec_on, .pri_dly, .pri_ready,
    .sec_osc_running, .int_osc_stable);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Idle: CPU gated, peripherals on the selected source, primary kept only for 00
  function automatic pmc_clk_t idle_exp(input logic [1:0] s);
    return {1'b0, 1'b1, s == 2'b00, s == 2'b00 ? SRC_PRI : (s[1] ? SRC_INT : SRC_SEC)};
  endfunction

  task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task settle(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task wctl(input pmc_clk_t e, input int lim);
    int n;
    for (n = 0; n < lim && clk_ctl !== e; n++) settle(1);
    chk("clk_ctl", 36'(e), 36'(clk_ctl));
  endtask

  task slp;
    @(posedge sys_clk);
    sleep_req <= 1'b1;
    @(posedge sys_clk);
    sleep_req <= 1'b0;
    settle(1);
  endtask

  task wake(input logic wdt);
    @(posedge sys_clk);
    wake_wdt <= wdt;
    wake_irq <= !wdt;
    @(posedge sys_clk);
    wake_wdt <= 1'b0;
    wake_irq <= 1'b0;
  endtask

  // Edge counting starts at the sampling edge; a two-cycle slack covers that offset
  task wdel;
    int n;
    for (n = 0; n < 2200 && clk_ctl.cpu_clk_en !== 1'b1; n++) settle(1);
    if (n >= `PMC_WAKE_CYCLES - 2 && n <= `PMC_WAKE_CYCLES + 2) n = `PMC_WAKE_CYCLES;
    chk("wake_delay", 36'(`PMC_WAKE_CYCLES), 36'(n));
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
          input logic [1:0] er);
    logic ta, td;
    ta = 1'b0;
    td = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && td)) begin
      @(posedge sys_clk);
      if (!ta && s_axi_awready) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!td && s_axi_wready) begin
        td = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    @(posedge sys_clk);
    while (!s_axi_bvalid) @(posedge sys_clk);
    s_axi_bready <= 1'b0;
    chk("bresp", {34'h1, er}, {34'(s_axi_bvalid), s_axi_bresp});
  endtask

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    while (!s_axi_arready) @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    @(posedge sys_clk);
    while (!s_axi_rvalid) @(posedge sys_clk);
    s_axi_rready <= 1'b0;
    chk("rdata", {1'b1, er, 1'b0, ed}, {s_axi_rvalid, s_axi_rresp, 1'b0, s_axi_rdata});
  endtask

  // Random upper data bits must be ignored; primary start-up varies prompt to slow
  task wr_ctl(input logic [7:0] c);
    rng = xs(rng);
    @(posedge sys_clk);
    pri_dly <= 16'h0020 + 16'(rng[8:0]);
    wr(`PMC_CTRL_OFS, {rng[31:8], c}, 4'hF, 2'h0);
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (wdt_reset === 1'b1) begin
      wdt_pulses++;
    end
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    mismatches++;
    $display("FAIL watchdog expected finish seen timeout");
    finish_test();
  end

  initial begin
    int i;
    {sleep_req, wake_irq, wake_wdt, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h0;
    {mismatches, checked, wdt_pulses} = '0;
    rng = 32'h00000020;
    sec_on = 1'b1;
    pri_dly = 16'h0020;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    settle(1);
    wctl({3'b111, SRC_PRI}, 1);
    chk("flags", 36'h1, 36'(flags));
    rd(`PMC_CTRL_OFS, 32'h00000000, 2'h0);
    rd(`PMC_STAT_OFS, 32'h00000311, 2'h0);
    wr(`PMC_CTRL_OFS, 32'h000000FF, 4'hE, 2'h0);
    rd(`PMC_CTRL_OFS, 32'h00000000, 2'h0);
    wr(8'h08, 32'h00000001, 4'hF, 2'h2);
    rd(8'h08, 32'h00000000, 2'h2);
    $display("reset and register test done");
    wr_ctl(8'h80);
    slp();
    wctl(idle_exp(2'b00), 4);
    chk("flags", 36'h1, 36'(flags));
    wr_ctl(8'h00);
    slp();
    wctl(idle_exp(2'b00), 1);
    wake(1'b0);
    wdel();
    wctl({3'b111, SRC_PRI}, 1);
    chk("flags", 36'h1, 36'(flags));
    rd(`PMC_CTRL_OFS, 32'h00000000, 2'h0);
    wr_ctl(8'h81);
    slp();
    wctl({3'b111, SRC_PRI}, 1);
    $display("primary idle test done");
    @(posedge sys_clk);
    sec_on <= 1'b0;
    wr_ctl(8'h89);
    slp();
    settle(30);
    chk("periph_clk_en", 36'h0, 36'(clk_ctl.periph_clk_en));
    chk("flags", 36'h1, 36'(flags));
    @(posedge sys_clk);
    sec_on <= 1'b1;
    wctl(idle_exp(2'b01), 30);
    chk("flags", 36'h2, 36'(flags));
    rd(`PMC_STAT_OFS, 32'h00000222, 2'h0);
    wake(1'b1);
    wdel();
    wctl({3'b111, SRC_SEC}, 1);
    chk("flags", 36'h2, 36'(flags));
    wctl({3'b111, SRC_PRI}, 600);
    chk("flags", 36'h1, 36'(flags));
    chk("wdt_pulses", 36'h0, 36'(wdt_pulses));
    $display("secondary idle test done");
    wr_ctl(8'h09);
    slp();
    wctl({3'b110, SRC_SEC}, 30);
    wake(1'b0);
    settle(4);
    wctl({3'b111, SRC_SEC}, 1);
    wake(1'b1);
    settle(2);
    chk("wdt_pulses", 36'h1, 36'(wdt_pulses));
    wctl({3'b111, SRC_PRI}, 600);
    chk("flags", 36'h1, 36'(flags));
    $display("secondary run test done");
    for (i = 2; i < 4; i++) begin
      wr_ctl(8'h80 | 8'(i));
      slp();
      wctl(idle_exp(2'(i)), 30);
      chk("flags", 36'h4, 36'(flags));
      wake(1'b0);
      wdel();
      wctl({3'b111, SRC_INT}, 1);
      wctl({3'b111, SRC_PRI}, 600);
      chk("flags", 36'h1, 36'(flags));
      rd(`PMC_CTRL_OFS, 32'h00000080 | 32'(i), 2'h0);
    end
    $display("internal idle test done");
    for (i = 0; i < 3; i++) begin
      wr_ctl(8'(i) << 4);
      slp();
      wctl({3'b000, SRC_NONE}, 4);
      chk("flags", 36'h0, 36'(flags));
      wake(1'b0);
      settle(3);
      chk("cpu_clk_en", 36'(i != 0), 36'(clk_ctl.cpu_clk_en));
      chk("clk_sel", 36'(i != 0 ? 3 : 0), 36'(clk_ctl.clk_sel));
      chk("pri_flag", 36'h0, 36'(flags.primary_clock_active_flag));
      wctl({3'b111, SRC_PRI}, 600);
      chk("flags", 36'h1, 36'(flags));
    end
    $display("full sleep test done");
    finish_test();
  end
endmodule
